// ---- hdl/bos_seq.sv ----
// Brownout, burst and hiccup OCP sequencer with APB registers
//
// What this block does
// - Demag current is compared to brownout_current_level while the switch is on.
// - Demag current below that level during on-time shuts switching down.
// - Comp 65 mV under burst_entry_level stops switching, gate held off.
// - In burst mode at most one pulse train per 500 us wake period.
// - After each 500 us idle, switch on again and evaluate feedback.
// - Error amplifier above burst_exit_level resumes; else another 500 us off.
// - Power-up begins in constant_current_mode.
// - Sense voltage above 1 V raises an overcurrent trip.
// - First trip from idle enters warning, converter keeps running.
// - No trip in the next switching cycle returns to idle.
// - Trip again in the next cycle is a fault; switching stops.
// - The overcurrent stop is latched while supplied.
// - Supply undervoltage clears the stop latch.
// - Start-up generator stays off until supply below restart level.
// - Burst threshold on comp level is taken as 1 V.
`timescale 1ns/1ps
module bos_seq #(
  parameter int unsigned WAKE_CYC = bos_pkg::BURST_WAKE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dmg_low_cmp,
  input wire logic comp_low_cmp,
  input wire logic error_amplifier_cmp,
  input wire logic ocp_cmp,
  input wire logic restart_cmp,
  output logic gate_en,
  output logic constant_current_mode,
  output logic startup_gen_en,
  output logic irq
);
  import bos_pkg::*;

  bos_cmp_t cmp;
  bos_seq_t seq_reg;
  bos_ocp_t ocp_state;
  logic ocp_warn;
  logic ocp_stop;
  logic [CNT_W-1:0] wake_cnt_reg;
  logic pulse_done_reg;
  logic gate_reg;
  logic gate_d_reg;
  logic restart_seen_reg;
  logic [31:0] ctrl_reg;
  logic [EVT_W-1:0] irq_stat_reg;
  logic [EVT_W-1:0] irq_mask_reg;
  logic [EVT_W-1:0] evt;
  logic sw_enable;
  logic apb_rd;
  logic apb_wr;
  logic wake_done;

  bos_sync u_sync_dmg (.pclk(pclk), .presetn(presetn),
    .async_in(dmg_low_cmp), .sync_out(cmp.brownout));
  bos_sync u_sync_comp (.pclk(pclk), .presetn(presetn),
    .async_in(comp_low_cmp), .sync_out(cmp.burst_entry));
  bos_sync u_sync_err (.pclk(pclk), .presetn(presetn),
    .async_in(error_amplifier_cmp), .sync_out(cmp.burst_exit));
  bos_sync u_sync_ocp (.pclk(pclk), .presetn(presetn),
    .async_in(ocp_cmp), .sync_out(cmp.ocp));
  bos_sync u_sync_rst (.pclk(pclk), .presetn(presetn),
    .async_in(restart_cmp), .sync_out(cmp.below_restart));

  assign cmp.cycle_end = gate_d_reg && !gate_reg;
  assign sw_enable = ctrl_reg[0];
  assign wake_done = (wake_cnt_reg == CNT_W'(WAKE_CYC - 1));

  bos_ocp u_ocp (
    .pclk(pclk),
    .presetn(presetn),
    .ocp(cmp.ocp),
    .cycle_end(cmp.cycle_end),
    .state(ocp_state),
    .warn_pulse(ocp_warn),
    .stop_pulse(ocp_stop)
  );

  // Sequencer; brownout only judged while the gate is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= SEQ_STARTUP;
    end else if (ocp_state == OCP_FAULT) begin
      seq_reg <= SEQ_OCP_STOP;
    end else if (gate_reg && cmp.brownout) begin
      seq_reg <= SEQ_BROWNOUT;
    end else begin
      case (seq_reg)
        SEQ_STARTUP: begin
          // Leaves constant-current start once feedback is in regulation
          if (cmp.burst_entry) begin
            seq_reg <= SEQ_BURST_IDLE;
          end else if (cmp.burst_exit) begin
            seq_reg <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (cmp.burst_entry) begin
            seq_reg <= SEQ_BURST_IDLE;
          end
        end
        SEQ_BURST_IDLE: begin
          if (wake_done) begin
            seq_reg <= SEQ_BURST_PROBE;
          end
        end
        SEQ_BURST_PROBE: begin
          if (cmp.cycle_end) begin
            if (cmp.burst_exit) begin
              seq_reg <= SEQ_RUN;
            end else begin
              seq_reg <= SEQ_BURST_IDLE;
            end
          end
        end
        SEQ_BROWNOUT: seq_reg <= SEQ_BROWNOUT;
        SEQ_OCP_STOP: seq_reg <= SEQ_OCP_STOP;
        default: seq_reg <= SEQ_STARTUP;
      endcase
    end
  end

  // Wake timer runs only while burst idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt_reg <= '0;
    end else if (seq_reg != SEQ_BURST_IDLE || wake_done) begin
      wake_cnt_reg <= '0;
    end else begin
      wake_cnt_reg <= wake_cnt_reg + CNT_W'(1);
    end
  end

  // One probe pulse per wake: pulse ends on first high-then-low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_done_reg <= 1'b0;
    end else if (seq_reg != SEQ_BURST_PROBE) begin
      pulse_done_reg <= 1'b0;
    end else if (gate_reg) begin
      pulse_done_reg <= 1'b1;
    end
  end

  // Gate is a request to the driver; single-cycle probe in burst
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_reg <= 1'b0;
      gate_d_reg <= 1'b0;
    end else begin
      gate_d_reg <= gate_reg;
      case (seq_reg)
        SEQ_STARTUP, SEQ_RUN: gate_reg <= sw_enable;
        SEQ_BURST_PROBE: gate_reg <= sw_enable && !pulse_done_reg
          && !gate_reg;
        default: gate_reg <= 1'b0;
      endcase
    end
  end

  // Start-up generator held off after a stop until supply is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_seen_reg <= 1'b0;
    end else if (seq_reg == SEQ_OCP_STOP && cmp.below_restart) begin
      restart_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_en <= 1'b0;
      constant_current_mode <= 1'b1;
      startup_gen_en <= 1'b0;
    end else begin
      gate_en <= gate_reg;
      constant_current_mode <= (seq_reg == SEQ_STARTUP);
      startup_gen_en <= (seq_reg == SEQ_OCP_STOP) && restart_seen_reg;
    end
  end

  // Events
  assign evt[EVT_BROWNOUT] = (seq_reg != SEQ_BROWNOUT) && gate_reg
    && cmp.brownout;
  assign evt[EVT_BURST] = (seq_reg == SEQ_RUN) && cmp.burst_entry;
  assign evt[EVT_OCP_WARN] = ocp_warn;
  assign evt[EVT_OCP_STOP] = ocp_stop;

  assign apb_rd = psel && penable && !pwrite;
  assign apb_wr = psel && penable && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      irq_mask_reg <= MASK_RST[EVT_W-1:0];
    end else if (apb_wr) begin
      if (paddr == CTRL_OFS) begin
        ctrl_reg <= pwdata;
      end
      if (paddr == MASK_OFS) begin
        irq_mask_reg <= pwdata[EVT_W-1:0];
      end
    end
  end

  // Read clears; a new event in the same cycle wins
  // Only bits already reported clear, so events after setup survive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
    end else if (apb_rd && paddr == IRQ_OFS) begin
      irq_stat_reg <= (irq_stat_reg & ~prdata[EVT_W-1:0]) | evt;
    end else begin
      irq_stat_reg <= irq_stat_reg | evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat_reg | evt) & irq_mask_reg);
    end
  end

  // Zero-wait slave: pready high in every access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable) begin
        case (paddr)
          CTRL_OFS: prdata <= ctrl_reg;
          STAT_OFS: prdata <= {24'h00_0000, 1'b0, ocp_state,
            cmp.ocp, seq_reg, gate_reg};
          IRQ_OFS: prdata <= {28'h000_0000, irq_stat_reg};
          MASK_OFS: prdata <= {28'h000_0000, irq_mask_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  a_burst_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_reg == SEQ_BURST_IDLE && wake_done) |=> seq_reg == SEQ_BURST_PROBE)
    else $error("burst wake missed");
  a_burst_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
    seq_reg == SEQ_BURST_IDLE |=> !gate_reg)
    else $error("gate on in burst idle");
  a_brownout_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (gate_reg && cmp.brownout && ocp_state != OCP_FAULT)
    |=> seq_reg == SEQ_BROWNOUT ##1 !gate_reg)
    else $error("brownout ignored");
  a_ocp_latch: assert property (@(posedge pclk) disable iff (!presetn)
    ocp_state == OCP_FAULT |=> ##1 seq_reg == SEQ_OCP_STOP ##1 !gate_reg)
    else $error("ocp fault not latched");
  a_ocp_first: assert property (@(posedge pclk) disable iff (!presetn)
    (ocp_state == OCP_IDLE && cmp.ocp) |=> ocp_state == OCP_WARN)
    else $error("first trip not warned");
  a_gate_out: assert property (@(posedge pclk) disable iff (!presetn)
    seq_reg == SEQ_OCP_STOP |=> ##1 !gate_en)
    else $error("gate output on after stop");
  a_startup_gen: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_reg == SEQ_OCP_STOP && !restart_seen_reg) |=> !startup_gen_en)
    else $error("start-up generator early");
  a_cc_start: assert property (@(posedge pclk) disable iff (!presetn)
    seq_reg == SEQ_STARTUP |=> constant_current_mode)
    else $error("not in constant current at start");
  a_cc_leave: assert property (@(posedge pclk) disable iff (!presetn)
    seq_reg != SEQ_STARTUP |=> !constant_current_mode)
    else $error("constant current held after start");

  // Terminal states hold until undervoltage
  a_brownout_hold: assert property (@(posedge pclk) disable iff (!presetn)
    seq_reg == SEQ_BROWNOUT |=> seq_reg == SEQ_BROWNOUT)
    else $error("brownout left without reset");
  a_brownout_gate: assert property (@(posedge pclk) disable iff (!presetn)
    seq_reg == SEQ_BROWNOUT |=> !gate_reg)
    else $error("gate on in brownout");
  a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
    seq_reg == SEQ_OCP_STOP |=> seq_reg == SEQ_OCP_STOP)
    else $error("ocp stop left without reset");
  a_fault_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ocp_state == OCP_FAULT |=> ocp_state == OCP_FAULT)
    else $error("ocp fault dropped");
  a_stop_gate: assert property (@(posedge pclk) disable iff (!presetn)
    seq_reg == SEQ_OCP_STOP |=> !gate_reg)
    else $error("gate on in ocp stop");
  a_restart_gen: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_reg == SEQ_OCP_STOP && restart_seen_reg) |=> startup_gen_en)
    else $error("start-up generator not released");

  // Burst timing and probe decisions
  a_burst_enter: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_reg == SEQ_RUN && cmp.burst_entry && ocp_state != OCP_FAULT
    && !(gate_reg && cmp.brownout)) |=> seq_reg == SEQ_BURST_IDLE)
    else $error("burst entry missed");
  a_idle_gate_en: assert property (@(posedge pclk) disable iff (!presetn)
    seq_reg == SEQ_BURST_IDLE |=> ##1 !gate_en)
    else $error("gate output on in burst idle");
  a_wake_bound: assert property (@(posedge pclk) disable iff (!presetn)
    seq_reg == SEQ_BURST_IDLE |-> wake_cnt_reg < CNT_W'(WAKE_CYC))
    else $error("wake counter overran");
  a_probe_single: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_reg == SEQ_BURST_PROBE && gate_reg) |=> !gate_reg)
    else $error("probe pulse too long");
  a_probe_resume: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_reg == SEQ_BURST_PROBE && cmp.cycle_end && cmp.burst_exit
    && ocp_state != OCP_FAULT) |=> seq_reg == SEQ_RUN)
    else $error("probe did not resume");
  a_probe_again: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_reg == SEQ_BURST_PROBE && cmp.cycle_end && !cmp.burst_exit
    && ocp_state != OCP_FAULT) |=> seq_reg == SEQ_BURST_IDLE)
    else $error("probe did not idle again");

  // Register side
  a_pready_access: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("access phase without ready");
  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    irq_mask_reg == '0 |=> !irq)
    else $error("interrupt with all sources masked");

  c_burst_probe: cover property (@(posedge pclk) disable iff (!presetn)
    seq_reg == SEQ_BURST_PROBE ##1 seq_reg == SEQ_RUN);
  c_burst_again: cover property (@(posedge pclk) disable iff (!presetn)
    seq_reg == SEQ_BURST_PROBE ##1 seq_reg == SEQ_BURST_IDLE);
  c_ocp_fault: cover property (@(posedge pclk) disable iff (!presetn)
    ocp_state == OCP_WARN ##1 ocp_state == OCP_FAULT);
  c_brownout: cover property (@(posedge pclk) disable iff (!presetn)
    seq_reg == SEQ_BROWNOUT);
  c_ocp_clear: cover property (@(posedge pclk) disable iff (!presetn)
    ocp_state == OCP_WARN ##1 ocp_state == OCP_IDLE);
endmodule : bos_seq

// ---- include/bos_pkg.sv ----
// Shared constants and carrier types for the brownout/burst/OCP sequencer
package bos_pkg;
  // Clock 40 MHz
  localparam int unsigned CLK_HZ = 40_000_000;
  // Burst wake interval, microseconds
  localparam int unsigned BURST_WAKE_US = 500;
  localparam int unsigned BURST_WAKE_CYC = BURST_WAKE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W = 16;
  // Analog thresholds in millivolts (brownout current in microamps), for reference by the front end
  localparam int BROWNOUT_UA = -50;
  localparam int BURST_HYST_MV = 65;
  localparam int BURST_LEVEL_MV = 1000;
  localparam int OCP_TRIP_MV = 1000;
  // APB map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0c;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam int unsigned EVT_W = 4;
  localparam int unsigned EVT_BROWNOUT = 0;
  localparam int unsigned EVT_BURST = 1;
  localparam int unsigned EVT_OCP_WARN = 2;
  localparam int unsigned EVT_OCP_STOP = 3;

  // Synchronised comparator bundle
  typedef struct packed {
    logic brownout;   // demag current below brownout_current_level
    logic burst_entry; // comp below burst_entry_level
    logic burst_exit;  // error_amplifier above burst_exit_level
    logic ocp;         // sense voltage over trip level
    logic below_restart; // supply below restart level
    logic cycle_end;   // switching cycle boundary (gate falling)
  } bos_cmp_t;

  typedef enum logic [2:0] {
    SEQ_STARTUP = 3'b000,
    SEQ_RUN = 3'b001,
    SEQ_BURST_IDLE = 3'b010,
    SEQ_BURST_PROBE = 3'b011,
    SEQ_BROWNOUT = 3'b100,
    SEQ_OCP_STOP = 3'b101
  } bos_seq_t;

  typedef enum logic [1:0] {
    OCP_IDLE = 2'b00,
    OCP_WARN = 2'b01,
    OCP_FAULT = 2'b10
  } bos_ocp_t;
endpackage : bos_pkg

// ---- hdl/bos_sync.sv ----
// Three-stage synchroniser with agreement filter for one comparator
`timescale 1ns/1ps
module bos_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        sync_out <= s3_reg;
      end
    end
  end
endmodule : bos_sync

// ---- hdl/bos_ocp.sv ----
// Two-strike overcurrent filter with stop latch
`timescale 1ns/1ps
module bos_ocp (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ocp,
  input wire logic cycle_end,
  output bos_pkg::bos_ocp_t state,
  output logic warn_pulse,
  output logic stop_pulse
);
  import bos_pkg::*;
  logic trip_reg;
  logic armed_reg;

  // First boundary only closes the cycle that held the first trip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
    end else if (state != OCP_WARN) begin
      armed_reg <= 1'b0;
    end else if (cycle_end) begin
      armed_reg <= 1'b1;
    end
  end

  // Trip seen in the current switching cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_reg <= 1'b0;
    end else if (cycle_end) begin
      trip_reg <= 1'b0;
    end else if (ocp) begin
      trip_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= OCP_IDLE;
      warn_pulse <= 1'b0;
      stop_pulse <= 1'b0;
    end else begin
      warn_pulse <= 1'b0;
      stop_pulse <= 1'b0;
      case (state)
        OCP_IDLE: begin
          if (ocp) begin
            state <= OCP_WARN;
            warn_pulse <= 1'b1;
          end
        end
        OCP_WARN: begin
          // Judged at the end of the following cycle
          if (cycle_end && armed_reg) begin
            if (trip_reg || ocp) begin
              state <= OCP_FAULT;
              stop_pulse <= 1'b1;
            end else begin
              state <= OCP_IDLE;
            end
          end
        end
        OCP_FAULT: state <= OCP_FAULT;
        default: state <= OCP_IDLE;
      endcase
    end
  end

  a_ocp_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (state == OCP_WARN && armed_reg && cycle_end && !trip_reg && !ocp)
    |=> state == OCP_IDLE)
    else $error("clean cycle faulted");
  a_ocp_arm: assert property (@(posedge pclk) disable iff (!presetn)
    (state == OCP_WARN && !armed_reg && cycle_end) |=> state == OCP_WARN)
    else $error("trip cycle judged as second strike");
endmodule : bos_ocp

// ---- dv/bos_plant_model.sv ----
// Plant model: power switch, sense resistor and auxiliary winding
`timescale 1ns/1ps
module bos_plant_model (
  input wire logic gate_en,
  input wire logic short_fault,
  input wire logic aux_open,
  output logic ocp_cmp,
  output logic dmg_low_cmp
);
  // Sense voltage builds only while the switch conducts
  assign ocp_cmp = gate_en & short_fault;
  // Demag current only flows in on-time; open winding draws none
  assign dmg_low_cmp = gate_en & aux_open;
endmodule : bos_plant_model

// ---- dv/burst_ocp_brownout_sequencer_tb.sv ----
// Testbench for the brownout, burst and hiccup sequencer
`timescale 1ns/1ps
module burst_ocp_brownout_sequencer_tb;
  import bos_pkg::*;
  // Short wake interval keeps the run brief
  localparam int unsigned WAKE = 20;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err;
  logic comp_low_cmp, error_amplifier_cmp, restart_cmp, short_fault;
  logic aux_open, dmg_low_cmp, ocp_cmp, gate_en, constant_current_mode;
  logic startup_gen_en, irq;
  int num_errors = 0;
  int cmp_count = 0;
  int t0, gap, pulses;

  bos_seq #(.WAKE_CYC(WAKE)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dmg_low_cmp(dmg_low_cmp), .comp_low_cmp(comp_low_cmp),
    .error_amplifier_cmp(error_amplifier_cmp), .ocp_cmp(ocp_cmp),
    .restart_cmp(restart_cmp), .gate_en(gate_en),
    .constant_current_mode(constant_current_mode),
    .startup_gen_en(startup_gen_en), .irq(irq));

  bos_plant_model u_plant (.gate_en(gate_en), .short_fault(short_fault),
    .aux_open(aux_open), .ocp_cmp(ocp_cmp), .dmg_low_cmp(dmg_low_cmp));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // One transfer; an idle cycle follows so signals never change twice
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Polls status until the masked field matches, bounded
  task automatic wait_stat(input string what, input logic [31:0] msk,
                           input logic [31:0] val);
    int n;
    n = 0;
    do begin
      apb(1'b0, STAT_OFS, 32'h0);
      n++;
    end while ((rd & msk) !== val && n < 400);
    check(what, rd & msk, val);
  endtask : wait_stat

  // Enable toggle ends one switching cycle on the gate
  task automatic cycle_pulse();
    repeat (8) @(posedge pclk);
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h1);
  endtask : cycle_pulse

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, comp_low_cmp, error_amplifier_cmp} = '0;
    {restart_cmp, short_fault, aux_open} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    check("cc mode", 32'(constant_current_mode), 32'h1);
    check("gate_en", 32'(gate_en), 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CTRL_OFS, 32'h0);
    check("ctrl", rd, CTRL_RST);
    apb(1'b0, MASK_OFS, 32'h0);
    check("mask", rd, MASK_RST);
    apb(1'b1, 8'h40, 32'hffff_ffff);
    check("unmapped", 32'(err), 32'h1);
    $display("test registers done");
    error_amplifier_cmp <= 1'b1;
    wait_stat("run", 32'he, 32'h2);
    check("cc mode off", 32'(constant_current_mode), 32'h0);
    error_amplifier_cmp <= 1'b0;
    comp_low_cmp <= 1'b1;
    wait_stat("burst", 32'he, 32'h4);
    check("irq masked", 32'(irq), 32'h0);
    apb(1'b1, MASK_OFS, 32'hf);
    repeat (3) @(posedge pclk);
    check("irq", 32'(irq), 32'h1);
    // Probes in burst must be at least one wake interval apart
    pulses = 0;
    gap = WAKE * 4;
    t0 = -WAKE * 4;
    for (int c = 0; c < WAKE * 3 + 10; c++) begin
      @(posedge pclk);
      if (gate_en === 1'b1) begin
        pulses++;
        if (c - t0 < gap)
          gap = c - t0;
        t0 = c;
      end
    end
    check("probes", 32'(pulses >= 2), 32'h1);
    check("probe gap", 32'(gap >= WAKE), 32'h1);
    wait_stat("stay burst", 32'he, 32'h4);
    apb(1'b0, IRQ_OFS, 32'h0);
    check("burst evt", 32'(rd[EVT_BURST]), 32'h1);
    repeat (3) @(posedge pclk);
    check("irq clr", 32'(irq), 32'h0);
    comp_low_cmp <= 1'b0;
    error_amplifier_cmp <= 1'b1;
    wait_stat("exit", 32'he, 32'h2);
    $display("test burst done");
    short_fault <= 1'b1;
    wait_stat("warn", 32'h6e, 32'h22);
    short_fault <= 1'b0;
    cycle_pulse();
    cycle_pulse();
    wait_stat("idle", 32'h6e, 32'h02);
    short_fault <= 1'b1;
    wait_stat("warn2", 32'h6e, 32'h22);
    cycle_pulse();
    cycle_pulse();
    wait_stat("stop", 32'he, 32'ha);
    short_fault <= 1'b0;
    check("gate stop", 32'(gate_en), 32'h0);
    apb(1'b0, IRQ_OFS, 32'h0);
    check("ocp evts", 32'(rd[3:2]), 32'h3);
    repeat (200) @(posedge pclk);
    wait_stat("latched", 32'he, 32'ha);
    check("gen off", 32'(startup_gen_en), 32'h0);
    restart_cmp <= 1'b1;
    repeat (20) @(posedge pclk);
    check("gen on", 32'(startup_gen_en), 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("uvlo cc", 32'(constant_current_mode), 32'h1);
    presetn <= 1'b1;
    restart_cmp <= 1'b0;
    wait_stat("cleared", 32'h6e, 32'h0);
    $display("test ocp done");
    apb(1'b1, MASK_OFS, 32'hf);
    wait_stat("run2", 32'he, 32'h2);
    aux_open <= 1'b1;
    wait_stat("brownout", 32'he, 32'h8);
    repeat (3) @(posedge pclk);
    check("gate bo", 32'(gate_en), 32'h0);
    apb(1'b0, IRQ_OFS, 32'h0);
    check("bo evt", 32'(rd[EVT_BROWNOUT]), 32'h1);
    $display("test brownout done");
    finish_test();
  end
endmodule : burst_ocp_brownout_sequencer_tb
